// ===== verilog/txcs_params.svh
// Offsets, reset values and timing counts of the transmit control block.
`ifndef TXCS_PARAMS_SVH
`define TXCS_PARAMS_SVH
`define TXCS_OFS_CTRL 4'h0
`define TXCS_OFS_STAT 4'h2
`define TXCS_CTRL_RST 16'h0000
`define TXCS_STAT_RST 16'h0000
`define TXCS_CLK_NS 5
`define TXCS_DEFR_NS 6400
`define TXCS_DEFR_CYC (`TXCS_DEFR_NS / `TXCS_CLK_NS)
`define TXCS_PRE_NIB 17'h0_000f
`define TXCS_IFG_NIB 17'h0_0017
`define TXCS_JAM_NIB 17'h0_0007
`define TXCS_CRC_NIB 17'h0_0007
`define TXCS_LATE_NIB 8'h80
`define TXCS_EXC_NIB 13'h17b8
`define TXCS_MIN_LEN 11'h040
`define TXCS_CRC_LEN 11'h004
`define TXCS_MAX_COLL 5'h10
`define TXCS_BOFF_LIM 5'h0a
`define TXCS_NIB_PRE 4'h5
`define TXCS_NIB_SFD 4'hd
`define TXCS_CRC_POLY 32'hedb8_8320
`define TXCS_CRC_INIT 32'hffff_ffff
`define TXCS_LFSR_SEED 16'hace1
`endif

// ===== verilog/txcs_pkg.sv
// Types shared by the transmit control block.
package txcs_pkg;
  typedef struct packed {
    logic swfd; logic rsv14; logic iloop; logic stop_sqe;
    logic rx_own; logic mon_cs; logic rsv9; logic no_crc;
    logic pad_en; logic [3:0] rsv6_3; logic force_col; logic loop_pin; logic tx_en;
  } txcs_ctrl_t;
  typedef struct packed {
    logic underrun; logic link_ok; logic rsv13; logic counter_rollover;
    logic excessive_deferral; logic lost_carrier; logic late_col; logic rsv8;
    logic deferred; logic last_brd; logic sqe; logic col16;
    logic last_mult; logic multi_col; logic single_col; logic success;
  } txcs_stat_t;
  typedef struct packed {
    logic underrun; logic lost; logic late; logic col16; logic sqe;
    logic defer; logic exc; logic brd; logic mult; logic start;
    logic fin; logic fatal; logic [4:0] ncol;
  } txcs_ev_t;
  typedef enum logic [10:0] {
    S_IDLE = 11'h001, S_IFG = 11'h002, S_PRE = 11'h004, S_DATA = 11'h008,
    S_PAD = 11'h010, S_CRC = 11'h020, S_JAM = 11'h040, S_BOFF = 11'h080,
    S_SQEW = 11'h100, S_FIN = 11'h200, S_WB = 11'h400
  } txcs_state_t;
endpackage

// ===== verilog/txcs_top.sv
// Transmit control and per-frame transmit status of a 10/100 MAC.
// Operation
// R1: Switched full duplex ignores carrier, never defers, and suppresses collision counting.
// R2: Full duplex uses collision as flow control; one-clock jam and backoff, preamble completes.
// R3: Full duplex makes receive-own and carrier-monitor bits irrelevant.
// R4: Internal loopback zeroes transmit pins and masks carrier, collision, receive inputs.
// R5: Stop-on-SQE halts transmitter on SQE failure; writing it zero clears SQE flag.
// R6: SQE flag sets in half duplex when no SQE pulse seen in gap; code sets it only while stop-on-SQE is set.
// R7: Receive-own bit accepts own frames; clear rejects frames sourced by this node.
// R8: Carrier monitor needs own carrier from preamble end; else abort and flag.
// R9: No-CRC bit suppresses the appended CRC; default appends it.
// R10: Padding extends short frames to 64 bytes with zeros; host gives raw count.
// R11: Force collision skips deferral; empty queue sends preamble when carrier appears.
// R12: Collision after 64 byte times flags late collision, jams, clears enable.
// R13: Loop bit drives loopback pin; link-ok follows inverted link pin, changes interrupt.
// R14: Clearing enable finishes the current frame; errors clear enable automatically.
// R15: Status holds last outcome and is written as first word per packet.
// R16: Underrun sets its flag and clears enable; setting enable clears flag.
// R17: Counter rollover flag sets at count 15, clears on counter read.
// R18: Excessive deferral and deferred flags track deferral; cleared at each packet boundary.
// R19: Broadcast and multicast flags describe the frame; cleared at frame start.
// R20: Sixteen collisions set their flag and clear enable; enable set clears it.
// R21: Single and multiple collision flags record collisions of the last frame.
// R22: Success flag sets on completion without fatal error; clears at start or enable.
`timescale 1ns/1ps
`include "txcs_params.svh"
module txcs_top import txcs_pkg::*; #(
  parameter logic [7:0] NIB_DIV = 8'h08
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        bus_sel,
  input  wire logic [3:0]  bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [1:0]  bus_be,
  input  wire logic [15:0] bus_wdata,
  output logic      [15:0] bus_rdata,
  input  wire logic        fr_pending,
  input  wire logic [10:0] fr_len,
  input  wire logic        fr_crc_ctl,
  output logic             fr_req,
  input  wire logic [7:0]  fr_data,
  input  wire logic        fr_data_ok,
  output logic             fr_done,
  output logic             st_wr,
  output logic      [15:0] st_word,
  input  wire logic        carrier_input,
  input  wire logic        collision_input,
  input  wire logic        rx_dv_in,
  input  wire logic        rx_er_in,
  output logic             rx_dv_out,
  output logic             rx_er_out,
  output logic             lb_valid,
  output logic      [3:0]  lb_data,
  output logic      [3:0]  txd,
  output logic             transmit_enable_out,
  output logic             loopback_pin,
  input  wire logic        link_input_pin_n,
  output logic             link_irq,
  input  wire logic        ctr_at_max,
  input  wire logic        ctr_read,
  input  wire logic        rx_addr_pass,
  input  wire logic        rx_from_self,
  output logic             rx_accept
);

  function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 4; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `TXCS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [9:0] boff_mask(input logic [4:0] n);
    logic [4:0] k;
    k = (n > `TXCS_BOFF_LIM) ? `TXCS_BOFF_LIM : n;
    return 10'((11'h001 << k) - 11'h001);
  endfunction

  txcs_ctrl_t  ctrl_reg;
  txcs_stat_t  stat_reg;
  txcs_stat_t  stat_next;
  txcs_ev_t    ev_reg;
  txcs_state_t st_reg;
  logic [7:0]  div_reg;
  logic        tick;
  logic [16:0] cnt_reg;
  logic [16:0] boff_reg;
  logic        half_reg;
  logic [10:0] bcnt_reg;
  logic [10:0] fidx_reg;
  logic [10:0] tgt_reg;
  logic [7:0]  cur_reg;
  logic [7:0]  nxt_reg;
  logic [7:0]  fnib_reg;
  logic [4:0]  ncol_reg;
  logic [31:0] crc_reg;
  logic [15:0] lfsr_reg;
  logic [12:0] dcnt_reg;
  logic [10:0] icyc_reg;
  logic        req_d_reg;
  logic        brd_acc_reg;
  logic        add_crc_reg;
  logic        col_pend_reg;
  logic        jam_fin_reg;
  logic        pre_only_reg;
  logic        fatal_reg;
  logic        sqe_seen_reg;
  logic        txen_i_reg;
  logic [3:0]  txd_i_reg;
  logic        lnk_reg;
  logic        crs;
  logic        col;
  logic        hd;
  logic        wr_ctrl;
  logic        tx_set;
  logic        coll_now;

  assign crs      = carrier_input & ~ctrl_reg.iloop; // R4
  assign col      = collision_input & ~ctrl_reg.iloop; // R4
  assign hd       = ~ctrl_reg.swfd;
  assign wr_ctrl  = bus_sel & bus_wr & ({bus_addr[3:1], 1'b0} == `TXCS_OFS_CTRL);
  assign tx_set   = wr_ctrl & bus_be[0] & bus_wdata[0];
  assign coll_now = tick & col & ~pre_only_reg;

  // The nibble rate is a strobe from a divider, keeping the whole block on one clock.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 8'h00;
      tick    <= 1'b0;
    end else begin
      tick    <= (div_reg == NIB_DIV - 8'h01);
      div_reg <= (div_reg == NIB_DIV - 8'h01) ? 8'h00 : div_reg + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= `TXCS_CTRL_RST;
    end else begin
      if (ev_reg.fatal) begin
        ctrl_reg.tx_en <= 1'b0; // R14 R16 R20 R12 R8 R5
      end
      if (wr_ctrl && bus_be[0]) begin
        ctrl_reg[7:0] <= bus_wdata[7:0];
      end
      if (wr_ctrl && bus_be[1]) begin
        ctrl_reg[15:8] <= bus_wdata[15:8];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_rdata <= 16'h0000;
    end else if (bus_sel && bus_rd) begin
      if ({bus_addr[3:1], 1'b0} == `TXCS_OFS_CTRL) begin
        bus_rdata <= ctrl_reg;
      end else if ({bus_addr[3:1], 1'b0} == `TXCS_OFS_STAT) begin
        bus_rdata <= stat_reg;
      end else begin
        bus_rdata <= 16'h0000;
      end
    end else begin
      bus_rdata <= 16'h0000;
    end
  end

  // Clears are applied first so that an event in the same cycle still lands.
  always_comb begin
    stat_next = stat_reg;
    stat_next.link_ok = lnk_reg; // R13
    if (tx_set) begin
      stat_next.underrun  = 1'b0; // R16
      stat_next.lost_carrier = 1'b0; // R8
      stat_next.late_col  = 1'b0; // R12
      stat_next.sqe       = 1'b0; // R6
      stat_next.col16     = 1'b0; // R20
      stat_next.success   = 1'b0; // R22
    end
    if (wr_ctrl && bus_be[1] && !bus_wdata[12]) begin
      stat_next.sqe = 1'b0; // R5
    end
    if (ctr_read) begin
      stat_next.counter_rollover = 1'b0; // R17
    end
    if (ev_reg.start) begin
      stat_next.last_brd  = 1'b0; // R19
      stat_next.last_mult = 1'b0; // R19
      stat_next.success   = 1'b0; // R22
      stat_next.deferred  = 1'b0; // R18
      stat_next.excessive_deferral   = 1'b0; // R18
    end
    if (ctr_at_max) stat_next.counter_rollover = 1'b1; // R17
    if (ev_reg.underrun) stat_next.underrun = 1'b1; // R16
    if (ev_reg.lost) stat_next.lost_carrier = 1'b1; // R8
    if (ev_reg.late) stat_next.late_col = 1'b1; // R12
    if (ev_reg.col16) stat_next.col16 = 1'b1; // R20
    if (ev_reg.sqe) stat_next.sqe = 1'b1; // R6
    if (ev_reg.defer) stat_next.deferred = 1'b1; // R18
    if (ev_reg.exc) stat_next.excessive_deferral = 1'b1; // R18
    if (ev_reg.brd) stat_next.last_brd = 1'b1; // R19
    if (ev_reg.mult) stat_next.last_mult = 1'b1; // R19
    if (ev_reg.fin) begin
      stat_next.success = ~ev_reg.fatal; // R22
      if (hd) begin
        stat_next.single_col = (ev_reg.ncol != 5'h00); // R21
        stat_next.multi_col  = (ev_reg.ncol > 5'h01); // R21
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stat_reg <= `TXCS_STAT_RST;
    end else begin
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= S_IDLE;
      ev_reg <= '0;
      cnt_reg <= 17'h0_0000;
      boff_reg <= 17'h0_0000;
      half_reg <= 1'b0;
      bcnt_reg <= 11'h000;
      fidx_reg <= 11'h000;
      tgt_reg <= 11'h000;
      cur_reg <= 8'h00;
      nxt_reg <= 8'h00;
      fnib_reg <= 8'h00;
      ncol_reg <= 5'h00;
      crc_reg <= `TXCS_CRC_INIT;
      lfsr_reg <= `TXCS_LFSR_SEED;
      dcnt_reg <= 13'h0000;
      icyc_reg <= 11'h000;
      req_d_reg <= 1'b0;
      brd_acc_reg <= 1'b0;
      add_crc_reg <= 1'b0;
      col_pend_reg <= 1'b0;
      jam_fin_reg <= 1'b0;
      pre_only_reg <= 1'b0;
      fatal_reg <= 1'b0;
      sqe_seen_reg <= 1'b0;
      txen_i_reg <= 1'b0;
      txd_i_reg <= 4'h0;
      fr_req <= 1'b0;
      fr_done <= 1'b0;
      st_wr <= 1'b0;
      st_word <= 16'h0000;
    end else begin
      ev_reg <= '0;
      fr_req <= 1'b0;
      fr_done <= 1'b0;
      st_wr <= 1'b0;
      req_d_reg <= fr_req;
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      if (icyc_reg != 11'h7ff) icyc_reg <= icyc_reg + 11'h001;
      if (tick && fnib_reg != 8'hff) fnib_reg <= fnib_reg + 8'h01;
      if (req_d_reg) begin
        nxt_reg <= fr_data;
        fidx_reg <= fidx_reg + 11'h001;
        brd_acc_reg <= ((fidx_reg == 11'h000) | brd_acc_reg) & (fr_data == 8'hff);
        if (fidx_reg == 11'h000) ev_reg.mult <= fr_data[0]; // R19
        if (fidx_reg == 11'h005) ev_reg.brd <= brd_acc_reg & (fr_data == 8'hff); // R19
        if (!fr_data_ok) begin
          ev_reg.underrun <= 1'b1; // R16
          fatal_reg <= 1'b1;
          st_reg <= S_FIN;
          txen_i_reg <= 1'b0;
        end
      end
      unique case (st_reg)
        S_IDLE: begin
          txen_i_reg <= 1'b0;
          // A cleared enable is only seen here, so a frame in flight always ends.
          if (ctrl_reg.tx_en && (fr_pending || ctrl_reg.force_col)) begin // R14
            st_reg <= S_IFG;
            cnt_reg <= 17'h0_0000;
            icyc_reg <= 11'h000;
            dcnt_reg <= 13'h0000;
            ncol_reg <= 5'h00;
            fatal_reg <= 1'b0;
            ev_reg.start <= fr_pending;
          end
        end
        S_IFG: if (tick) begin
          if (hd && !ctrl_reg.force_col && crs) begin // R1 R11
            cnt_reg <= 17'h0_0000;
            if (icyc_reg < 11'(`TXCS_DEFR_CYC)) ev_reg.defer <= 1'b1; // R18
            if (dcnt_reg != 13'h1fff) dcnt_reg <= dcnt_reg + 13'h0001;
            if (dcnt_reg == `TXCS_EXC_NIB) ev_reg.exc <= 1'b1; // R18
          end else if (cnt_reg < `TXCS_IFG_NIB) begin
            cnt_reg <= cnt_reg + 17'h0_0001;
          end else if (fr_pending || (ctrl_reg.force_col && crs)) begin // R11
            st_reg <= S_PRE;
            pre_only_reg <= ~fr_pending;
            cnt_reg <= 17'h0_0000;
            fnib_reg <= 8'h00;
            fidx_reg <= 11'h000;
            bcnt_reg <= 11'h000;
            col_pend_reg <= 1'b0;
            crc_reg <= `TXCS_CRC_INIT;
            add_crc_reg <= ~ctrl_reg.no_crc | fr_crc_ctl; // R9
            tgt_reg <= (~ctrl_reg.no_crc | fr_crc_ctl) ?
                       (`TXCS_MIN_LEN - `TXCS_CRC_LEN) : `TXCS_MIN_LEN; // R10
          end else if (!ctrl_reg.force_col) begin
            st_reg <= S_IDLE;
          end
        end
        S_PRE: if (tick) begin
          txen_i_reg <= 1'b1;
          txd_i_reg <= (cnt_reg == `TXCS_PRE_NIB && !pre_only_reg) ?
                       `TXCS_NIB_SFD : `TXCS_NIB_PRE; // R11
          cnt_reg <= cnt_reg + 17'h0_0001;
          if (cnt_reg == `TXCS_PRE_NIB - 17'h0_0001 && !pre_only_reg) fr_req <= 1'b1;
          if (coll_now && !hd) col_pend_reg <= 1'b1; // R2
          if (coll_now && hd) begin
            ncol_reg <= ncol_reg + 5'h01;
            cnt_reg <= 17'h0_0000;
            jam_fin_reg <= (ncol_reg + 5'h01 == `TXCS_MAX_COLL);
            fatal_reg <= (ncol_reg + 5'h01 == `TXCS_MAX_COLL);
            st_reg <= S_JAM;
          end else if (cnt_reg == `TXCS_PRE_NIB) begin
            if (pre_only_reg) begin
              st_reg <= S_IDLE;
            end else if (hd && ctrl_reg.mon_cs && !crs) begin // R8 R3
              ev_reg.lost <= 1'b1;
              fatal_reg <= 1'b1;
              st_reg <= S_FIN;
            end else if (col_pend_reg || (coll_now && !hd)) begin // R2
              st_reg <= S_JAM;
            end else begin
              st_reg <= S_DATA;
              half_reg <= 1'b0;
              cur_reg <= nxt_reg;
            end
          end
        end
        S_DATA, S_PAD: if (tick) begin
          txd_i_reg <= (st_reg == S_PAD) ? 4'h0 : (half_reg ? cur_reg[7:4] : cur_reg[3:0]);
          crc_reg <= crc_nib(crc_reg, (st_reg == S_PAD) ? 4'h0 :
                             (half_reg ? cur_reg[7:4] : cur_reg[3:0]));
          half_reg <= ~half_reg;
          if (!half_reg && st_reg == S_DATA && bcnt_reg + 11'h002 <= fr_len) fr_req <= 1'b1;
          if (half_reg) begin
            bcnt_reg <= bcnt_reg + 11'h001;
            cur_reg <= nxt_reg;
            if (st_reg == S_DATA ? (bcnt_reg + 11'h001 == fr_len) :
                                   (bcnt_reg + 11'h001 >= tgt_reg)) begin
              if (st_reg == S_DATA && ctrl_reg.pad_en && fr_len < tgt_reg) begin
                st_reg <= S_PAD; // R10
              end else if (add_crc_reg) begin
                st_reg <= S_CRC; // R9
                cnt_reg <= 17'h0_0000;
              end else begin
                st_reg <= hd ? S_SQEW : S_FIN;
                cnt_reg <= 17'h0_0000;
                sqe_seen_reg <= 1'b0;
              end
            end
          end
          if (hd && ctrl_reg.mon_cs && !crs) begin // R8 R3
            ev_reg.lost <= 1'b1;
            fatal_reg <= 1'b1;
            st_reg <= S_FIN;
          end
        end
        S_CRC: if (tick) begin
          txd_i_reg <= ~crc_reg[3:0];
          crc_reg <= {4'hf, crc_reg[31:4]};
          cnt_reg <= cnt_reg + 17'h0_0001;
          if (cnt_reg == `TXCS_CRC_NIB) begin
            st_reg <= hd ? S_SQEW : S_FIN;
            cnt_reg <= 17'h0_0000;
            sqe_seen_reg <= 1'b0;
          end
        end
        S_JAM: begin
          // Full duplex jams for a single clock before backing off.
          if (!hd) begin // R2
            txen_i_reg <= 1'b1;
            txd_i_reg <= `TXCS_NIB_PRE;
            st_reg <= S_BOFF;
          end else if (tick) begin
            txen_i_reg <= 1'b1;
            txd_i_reg <= `TXCS_NIB_PRE;
            cnt_reg <= cnt_reg + 17'h0_0001;
            if (cnt_reg == `TXCS_JAM_NIB) begin
              if (jam_fin_reg) begin
                st_reg <= S_FIN;
                ev_reg.late <= fatal_reg && fnib_reg >= `TXCS_LATE_NIB; // R12
                ev_reg.col16 <= (ncol_reg == `TXCS_MAX_COLL); // R20
              end else begin
                st_reg <= S_BOFF;
                cnt_reg <= 17'h0_0000;
                boff_reg <= {lfsr_reg[9:0] & boff_mask(ncol_reg), 7'h00};
              end
            end
          end
        end
        S_BOFF: begin
          if (tick || !hd) txen_i_reg <= 1'b0;
          if (!hd || (tick && cnt_reg >= boff_reg)) begin // R2
            st_reg <= S_IFG;
            cnt_reg <= 17'h0_0000;
            icyc_reg <= 11'h000;
          end else if (tick) begin
            cnt_reg <= cnt_reg + 17'h0_0001;
          end
        end
        S_SQEW: begin
          if (tick) txen_i_reg <= 1'b0;
          if (col) sqe_seen_reg <= 1'b1;
          if (tick) begin
            cnt_reg <= cnt_reg + 17'h0_0001;
            if (cnt_reg == `TXCS_IFG_NIB) begin
              st_reg <= S_FIN;
              if (ctrl_reg.stop_sqe && !sqe_seen_reg && !col) begin // R5 R6
                ev_reg.sqe <= 1'b1;
                fatal_reg <= 1'b1;
              end
            end
          end
        end
        S_FIN: if (tick || !txen_i_reg) begin
          txen_i_reg <= 1'b0;
          ev_reg.fin <= 1'b1;
          ev_reg.fatal <= fatal_reg; // R14
          ev_reg.ncol <= ncol_reg; // R21
          st_reg <= S_WB;
        end
        S_WB: begin
          st_wr <= 1'b1; // R15
          st_word <= stat_next; // R15
          fr_done <= 1'b1;
          st_reg <= S_IDLE;
        end
        default: st_reg <= S_IDLE;
      endcase
      // Half duplex collisions in the frame body count, then jam and retry or fail.
      if ((st_reg == S_DATA || st_reg == S_PAD || st_reg == S_CRC) && coll_now) begin
        cnt_reg <= 17'h0_0000;
        st_reg <= S_JAM;
        if (hd) begin // R1
          ncol_reg <= ncol_reg + 5'h01;
          jam_fin_reg <= (fnib_reg >= `TXCS_LATE_NIB) ||
                         (ncol_reg + 5'h01 == `TXCS_MAX_COLL); // R12 R20
          fatal_reg <= (fnib_reg >= `TXCS_LATE_NIB) ||
                       (ncol_reg + 5'h01 == `TXCS_MAX_COLL);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txd <= 4'h0;
      transmit_enable_out <= 1'b0;
      lb_valid <= 1'b0;
      lb_data <= 4'h0;
      rx_dv_out <= 1'b0;
      rx_er_out <= 1'b0;
    end else begin
      txd <= ctrl_reg.iloop ? 4'h0 : txd_i_reg; // R4
      transmit_enable_out <= ~ctrl_reg.iloop & txen_i_reg; // R4
      lb_valid <= ctrl_reg.iloop & txen_i_reg; // R4
      lb_data <= ctrl_reg.iloop ? txd_i_reg : 4'h0;
      rx_dv_out <= rx_dv_in & ~ctrl_reg.iloop; // R4
      rx_er_out <= rx_er_in & ~ctrl_reg.iloop; // R4
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      loopback_pin <= 1'b0;
      lnk_reg <= 1'b0;
      link_irq <= 1'b0;
      rx_accept <= 1'b0;
    end else begin
      loopback_pin <= ctrl_reg.loop_pin; // R13
      lnk_reg <= ~link_input_pin_n; // R13
      link_irq <= (~link_input_pin_n) != lnk_reg; // R13
      // In full duplex the own-frame choice is fixed and the control bit is ignored.
      rx_accept <= rx_addr_pass & (~rx_from_self | (ctrl_reg.rx_own & hd)); // R7 R3
    end
  end

endmodule

// ===== testbench/txcs_asserts.sv
// Port-level checker for the transmit control block.
`timescale 1ns/1ps
module txcs_asserts import txcs_pkg::*; #(
  parameter logic [7:0] NIB_DIV = 8'h08
) (
  input wire logic        clk, nrst, bus_sel, bus_wr, bus_rd, st_wr, fr_done,
  input wire logic [3:0]  bus_addr, txd,
  input wire logic [1:0]  bus_be,
  input wire logic [15:0] bus_wdata,
  input wire logic        rx_dv_in, rx_er_in, rx_dv_out, rx_er_out, transmit_enable_out,
  input wire logic        loopback_pin, link_input_pin_n, link_irq,
  input wire logic        rx_addr_pass, rx_from_self, rx_accept
);
  logic [15:0] c_reg;
  // Shadow of the control word; only the enable bit may differ, and no check reads it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      c_reg <= 16'h0000;
    end else if (bus_sel && bus_wr && bus_addr[3:1] == 3'h0) begin
      if (bus_be[0]) c_reg[7:0] <= bus_wdata[7:0];
      if (bus_be[1]) c_reg[15:8] <= bus_wdata[15:8];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  loop_pin_a: assert property ($stable(c_reg[1]) |-> loopback_pin == c_reg[1])
    else $error("loopback pin differs from control bit");
  iloop_tx_a: assert property (c_reg[13] && $past(c_reg[13]) |->
    txd == 4'h0 && !transmit_enable_out) else $error("transmit pins active in loopback");
  iloop_rx_a: assert property (c_reg[13] && $past(c_reg[13]) |->
    !rx_dv_out && !rx_er_out) else $error("receive inputs not blocked in loopback");
  rx_pass_a: assert property ($past(nrst) && !c_reg[13] && !$past(c_reg[13]) |->
    rx_dv_out == $past(rx_dv_in) && rx_er_out == $past(rx_er_in))
    else $error("receive inputs not passed through");
  rx_accept_a: assert property ($past(nrst) |-> rx_accept ==
    $past(rx_addr_pass && (!rx_from_self || (c_reg[11] && !c_reg[15]))))
    else $error("own-frame acceptance wrong");
  link_quiet_a: assert property ($stable(link_input_pin_n) [*4] |-> !link_irq)
    else $error("link interrupt without pin change");
  link_irq_a: assert property ($changed(link_input_pin_n) |-> ##[0:3] link_irq)
    else $error("link change raised no interrupt");
  done_pair_a: assert property (st_wr || fr_done |-> st_wr && fr_done)
    else $error("status write and frame done apart");
  done_pulse_a: assert property (fr_done |=> !fr_done)
    else $error("frame done longer than one cycle");
endmodule
bind txcs_top txcs_asserts #(.NIB_DIV(NIB_DIV)) u_chk (.clk, .nrst, .bus_sel, .bus_wr,
  .bus_rd, .st_wr, .fr_done, .bus_addr, .txd, .bus_be, .bus_wdata, .rx_dv_in, .rx_er_in,
  .rx_dv_out, .rx_er_out, .transmit_enable_out, .loopback_pin, .link_input_pin_n,
  .link_irq, .rx_addr_pass, .rx_from_self, .rx_accept);

// ===== testbench/txcs_phy_model.sv
// Behavioural PHY facing the transmit pins of the block.
`timescale 1ns/1ps
module txcs_phy_model (
  input  wire logic clk,
  input  wire logic txen,
  input  wire logic slow,
  input  wire logic col_cmd,
  input  wire logic rx_cmd,
  output logic      crs,
  output logic      col,
  output logic      rx_dv,
  output logic      rx_er
);
  logic [2:0] echo_reg;
  // Own carrier returns late, as through a real line; slow mode stretches the lag.
  always_ff @(posedge clk) echo_reg <= {echo_reg[1:0], txen};
  assign crs   = (slow ? echo_reg[2] : echo_reg[0]) | rx_cmd;
  assign col   = col_cmd & txen;
  assign rx_dv = rx_cmd;
  assign rx_er = rx_cmd;
endmodule

// ===== testbench/mac_tx_control_and_status_tb.sv
// Self-checking bench for the transmit control block.
`timescale 1ns/1ps
module mac_tx_control_and_status_tb;
  logic        clk, nrst, bus_sel, bus_wr, bus_rd, fr_pending, fr_crc_ctl, fr_data_ok;
  logic        fr_req, fr_done, st_wr, carrier_input, collision_input, rx_dv_in, rx_er_in;
  logic        transmit_enable_out, link_input_pin_n, ctr_at_max, ctr_read;
  logic        col_cmd, rx_cmd, late_en;
  logic [3:0]  bus_addr;
  logic [1:0]  bus_be;
  logic [10:0] fr_len;
  logic [7:0]  fr_data;
  logic [15:0] bus_wdata, bus_rdata, st_word, st_seen;
  int          err_count, checks_done, cyc, txc;
  txcs_top #(.NIB_DIV(8'h02)) DUT (.clk, .nrst, .bus_sel, .bus_addr, .bus_wr, .bus_rd,
    .bus_be, .bus_wdata, .bus_rdata, .fr_pending, .fr_len, .fr_crc_ctl, .fr_req,
    .fr_data, .fr_data_ok, .fr_done, .st_wr, .st_word, .carrier_input,
    .collision_input, .rx_dv_in, .rx_er_in, .rx_dv_out(), .rx_er_out(), .lb_valid(),
    .lb_data(), .txd(), .transmit_enable_out, .loopback_pin(), .link_input_pin_n,
    .link_irq(), .ctr_at_max, .ctr_read, .rx_addr_pass(1'b1), .rx_from_self(1'b1),
    .rx_accept());
  txcs_phy_model PHY (.clk, .txen(transmit_enable_out), .slow(late_en), .col_cmd,
    .rx_cmd, .crs(carrier_input), .col(collision_input), .rx_dv(rx_dv_in), .rx_er(rx_er_in));
  // Collide only just past the late window so the retry path is never taken.
  assign col_cmd = late_en && txc > 260;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) if (fr_req) fr_pending = 1'b0;
  always @(posedge clk) begin
    cyc++;
    if (transmit_enable_out) txc++;
    if (st_wr) st_seen <= st_word;
    if (cyc == 40000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge clk);
    {bus_sel, bus_wr, bus_addr, bus_be, bus_wdata} = {2'b11, a, be, d};
    @(negedge clk);
    {bus_sel, bus_wr} = 2'b00;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(negedge clk);
    {bus_sel, bus_rd, bus_addr} = {2'b11, a};
    @(negedge clk);
    {bus_sel, bus_rd} = 2'b00;
    chk("register read", e, bus_rdata & m);
  endtask
  task automatic frame(input logic [15:0] ctl, input logic [10:0] len, input logic ok,
    input logic late, input logic [15:0] m, input logic [15:0] e, input int nib);
    wr(4'h0, 2'b11, ctl | 16'h0001);
    fr_len = len;
    fr_data_ok = ok;
    late_en = late;
    txc = 0;
    fr_pending = 1'b1;
    for (int i = 0; i < 4000 && fr_done !== 1'b1; i++) @(negedge clk);
    chk("frame done", 16'h0001, {15'h0000, fr_done});
    @(negedge clk);
    late_en = 1'b0;
    chk("status word", e, st_seen & m);
    if (nib >= 0) chk("enable cycles", 16'(nib * 2), 16'(txc));
  endtask
  initial begin
    {nrst, bus_sel, bus_wr, bus_rd, bus_addr, bus_be, bus_wdata} = '0;
    {fr_pending, fr_len, fr_crc_ctl, fr_data_ok, rx_cmd, late_en, fr_data} = '0;
    {link_input_pin_n, ctr_at_max, ctr_read} = 3'b100;
    {err_count, checks_done, cyc, txc} = '0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    rd(4'h0, 16'hffff, 16'h0000);
    rd(4'h2, 16'hffff, 16'h0000);
    rx_cmd = 1'b1;
    wr(4'h0, 2'b11, 16'hfffe);
    rd(4'h0, 16'hffff, 16'hfffe);
    wr(4'h0, 2'b01, 16'h0000);
    rd(4'h0, 16'hffff, 16'hff00);
    wr(4'h4, 2'b11, 16'h1234);
    rd(4'h4, 16'hffff, 16'h0000);
    wr(4'h0, 2'b11, 16'h0800);
    rx_cmd = 1'b0;
    link_input_pin_n = 1'b0;
    repeat (4) @(negedge clk);
    rd(4'h2, 16'h4000, 16'h4000);
    link_input_pin_n = 1'b1;
    ctr_at_max = 1'b1;
    @(negedge clk);
    ctr_at_max = 1'b0;
    rd(4'h2, 16'h1000, 16'h1000);
    ctr_read = 1'b1;
    @(negedge clk);
    ctr_read = 1'b0;
    rd(4'h2, 16'h1000, 16'h0000);
    frame(16'h0080, 11'h00a, 1'b1, 1'b0, 16'hffff, 16'h0001, 'h90);
    fr_data = 8'hff;
    frame(16'h0100, 11'h00a, 1'b1, 1'b0, 16'hffff, 16'h0049, 'h24);
    fr_data = 8'h00;
    frame(16'h2100, 11'h00a, 1'b1, 1'b0, 16'hffff, 16'h0001, 'h00);
    frame(16'h1000, 11'h00a, 1'b1, 1'b0, 16'h8021, 16'h0020, 'h2c);
    wr(4'h0, 2'b10, 16'h0000);
    rd(4'h2, 16'h0020, 16'h0000);
    frame(16'h2400, 11'h00a, 1'b1, 1'b0, 16'h8401, 16'h0400, -1);
    frame(16'h0080, 11'h00a, 1'b0, 1'b0, 16'h8001, 16'h8000, -1);
    rd(4'h0, 16'h0001, 16'h0000);
    frame(16'h0080, 11'h064, 1'b1, 1'b1, 16'h8201, 16'h0200, -1);
    rd(4'h0, 16'h0001, 16'h0000);
    wr(4'h0, 2'b11, 16'h0001);
    rd(4'h2, 16'h8201, 16'h0000);
    end_of_test();
  end
endmodule
